// ---- fpc_defines.svh ----
// Offsets, field positions, reset values and timing figures of the flash protect block
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
// Address pages of the two register groups and memory windows
`define FPC_PAGE_FLASHCTL 20'h400fd
`define FPC_PAGE_SYSCTL 20'h400fe
`define FPC_TOP_FLASH 8'h00
`define FPC_TOP_SRAM 8'h20
`define FPC_TOP_BITBAND 8'h22
// Flash control page offsets
`define FPC_OFF_ADDR 12'h000
`define FPC_OFF_DATA 12'h004
`define FPC_OFF_CTRL 12'h008
`define FPC_OFF_RIS 12'h00c
`define FPC_OFF_IM 12'h010
`define FPC_OFF_MISC 12'h014
// System control page offsets
`define FPC_OFF_PRE0 12'h130
`define FPC_OFF_PPE0 12'h134
`define FPC_OFF_PRE1 12'h138
`define FPC_OFF_PPE1 12'h13c
`define FPC_OFF_USEC 12'h140
// Control word fields
`define FPC_KEY 16'ha442
`define FPC_CTL_WRITE 0
`define FPC_CTL_ERASE 1
`define FPC_CTL_MERASE 2
`define FPC_CTL_COMMIT 3
// Status and mask bit positions
`define FPC_IRQ_ACCESS 0
`define FPC_IRQ_PROG 1
// Reset values
`define FPC_USEC_RESET 8'h31
`define FPC_PROT_RESET 32'hffff_ffff
// Operation times in microseconds
`define FPC_PROG_USEC 16'd20
`define FPC_ERASE_USEC 16'd20
`endif

// ---- fpc_pkg.sv ----
// Types shared by the flash protect and SRAM bank block
package fpc_pkg;
   typedef enum logic [2:0] {FPC_K_NONE, FPC_K_FLASH, FPC_K_SRAM, FPC_K_BB, FPC_K_REG} fpc_kind_t;
   typedef enum logic [1:0] {FPC_IDLE, FPC_WAIT, FPC_WALK} fpc_state_t;
   typedef struct packed {
      fpc_kind_t kind;
      logic fetch;
      logic [31:0] addr;
   } fpc_req_t;
endpackage : fpc_pkg

// ---- fpc_flash_protect.sv ----
// Flash protection, flash controller and even/odd SRAM banks behind an AHB-Lite slave
`include "fpc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_protect #(
   parameter int FLASH_KB = 128,
   parameter int SRAM_KB = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic por_n,
   input wire logic factory_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic bus_fault,
   output logic flash_irq
);
   localparam int FLASH_WORDS = FLASH_KB * 256;
   localparam int FAW = $clog2(FLASH_WORDS);
   localparam int BW = $clog2(SRAM_KB * 128);
   localparam int RGW = FAW - 9;

   logic [31:0] flash_mem [FLASH_WORDS];
   logic [31:0] sram_even [SRAM_KB * 128];
   logic [31:0] sram_odd [SRAM_KB * 128];
   logic [31:0] flash_address_reg, fmd;
   logic [1:0] im, ris;
   logic [7:0] usec, ucnt;
   logic [15:0] usec_left;
   logic [3:0] ctl_op;
   logic [63:0] pre, ppe, nv_pre, nv_ppe;
   logic restore;
   logic [FAW-1:0] walk;
   logic done_p, viol_p;
   fpc_pkg::fpc_state_t state;
   fpc_pkg::fpc_req_t dp, held;
   logic dp_wr, rd_pend;

   // Address phase decode into a request record
   wire addr_ph = hsel && hready && htrans[1];
   wire hit_flash = haddr[31:24] == `FPC_TOP_FLASH && haddr[23:FAW+2] == '0;
   wire hit_sram = haddr[31:24] == `FPC_TOP_SRAM && haddr[23:BW+3] == '0;
   wire hit_bb = haddr[31:24] == `FPC_TOP_BITBAND && haddr[23:BW+8] == '0;
   wire hit_reg = haddr[31:12] == `FPC_PAGE_FLASHCTL || haddr[31:12] == `FPC_PAGE_SYSCTL;
   fpc_pkg::fpc_kind_t new_kind;
   fpc_pkg::fpc_req_t new_req, req;
   assign new_kind = hit_flash ? fpc_pkg::FPC_K_FLASH : hit_sram ? fpc_pkg::FPC_K_SRAM :
                     hit_bb ? fpc_pkg::FPC_K_BB : hit_reg ? fpc_pkg::FPC_K_REG : fpc_pkg::FPC_K_NONE;
   assign new_req = '{kind: new_kind, fetch: ~hprot[0], addr: haddr};
   assign req = rd_pend ? held : new_req;
   wire req_valid = rd_pend || (addr_ph && !hwrite);

   // Bank, index and bit position of the read and of the pending write
   wire req_bb = req.kind == fpc_pkg::FPC_K_BB;
   wire dp_bb = dp.kind == fpc_pkg::FPC_K_BB;
   wire req_ram = req_bb || req.kind == fpc_pkg::FPC_K_SRAM;
   wire dp_ram = dp_bb || dp.kind == fpc_pkg::FPC_K_SRAM;
   wire req_bank = req_bb ? req.addr[7] : req.addr[2];
   wire dp_bank = dp_bb ? dp.addr[7] : dp.addr[2];
   wire [BW-1:0] req_idx = req_bb ? req.addr[BW+7:8] : req.addr[BW+2:3];
   wire [BW-1:0] dp_idx = dp_bb ? dp.addr[BW+7:8] : dp.addr[BW+2:3];
   wire [4:0] req_pos = req.addr[6:2];
   wire [4:0] dp_pos = dp.addr[6:2];

   wire same_bank = dp_wr && req_ram && dp_ram && req_bank == dp_bank;
   // Register read after register write waits for the write to land
   wire reg_after_wr = dp_wr && req.kind == fpc_pkg::FPC_K_REG && dp.kind == fpc_pkg::FPC_K_REG;
   wire flash_held = req.kind == fpc_pkg::FPC_K_FLASH && state != fpc_pkg::FPC_IDLE;
   wire conflict = same_bank || reg_after_wr || flash_held;
   wire rd_ok = req_valid && !conflict;
   wire rd_stall = req_valid && conflict;

   // SRAM read value, whole word or single bit-band bit
   wire [31:0] ram_word = req_bank ? sram_odd[req_idx] : sram_even[req_idx];
   wire [31:0] ram_val = req_bb ? {31'h0, ram_word[req_pos]} : ram_word;

   // fetches always pass, data reads need read enable
   // one enable bit per 2 KB region
   wire [RGW-1:0] req_rgn = req.addr[FAW+1:11];
   // core and debugger data reads blocked
   wire rd_fault = req.kind == fpc_pkg::FPC_K_FLASH && !req.fetch && !pre[req_rgn];
   wire [31:0] flash_val = rd_fault ? 32'h0 : flash_mem[req.addr[FAW+1:2]];

   // Register read mux
   wire req_sys = req.addr[31:12] == `FPC_PAGE_SYSCTL;
   wire [11:0] ro = req.addr[11:0];
   wire [31:0] fc_val = ro == `FPC_OFF_ADDR ? flash_address_reg : ro == `FPC_OFF_DATA ? fmd :
                        ro == `FPC_OFF_CTRL ? {28'h0, ctl_op} :
                        ro == `FPC_OFF_RIS ? {30'h0, ris} :
                        ro == `FPC_OFF_IM ? {30'h0, im} :
                        ro == `FPC_OFF_MISC ? {30'h0, ris & im} : 32'h0;
   wire [31:0] sc_val = ro == `FPC_OFF_PRE0 ? pre[31:0] : ro == `FPC_OFF_PPE0 ? ppe[31:0] :
                        ro == `FPC_OFF_PRE1 ? pre[63:32] : ro == `FPC_OFF_PPE1 ? ppe[63:32] :
                        ro == `FPC_OFF_USEC ? {24'h0, usec} : 32'h0;
   wire [31:0] read_val = req.kind == fpc_pkg::FPC_K_FLASH ? flash_val : req_ram ? ram_val :
                          req.kind == fpc_pkg::FPC_K_REG ? (req_sys ? sc_val : fc_val) : 32'h0;

   // Bus side: write data phase capture, read stall and read answer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr <= 1'b0;
         dp <= '0;
         rd_pend <= 1'b0;
         held <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         bus_fault <= 1'b0;
      end
      else
      begin
         dp_wr <= addr_ph && hwrite;
         if (addr_ph && hwrite)
            dp <= new_req;
         rd_pend <= rd_stall;
         if (rd_stall)
            held <= req;
         hreadyout <= !rd_stall;
         hresp <= 1'b0;
         bus_fault <= rd_ok && rd_fault;
         if (rd_ok)
            hrdata <= read_val;
      end
   end

   // SRAM banks take the pending write in its data phase
   always_ff @(posedge hclk)
   begin
      if (dp_wr && dp_ram && dp_bank)
      begin
         if (dp_bb)
            sram_odd[dp_idx][dp_pos] <= hwdata[0];
         else
            sram_odd[dp_idx] <= hwdata;
      end
      if (dp_wr && dp_ram && !dp_bank)
      begin
         if (dp_bb)
            sram_even[dp_idx][dp_pos] <= hwdata[0];
         else
            sram_even[dp_idx] <= hwdata;
      end
   end

   // Register write strobes
   wire dp_reg = dp_wr && dp.kind == fpc_pkg::FPC_K_REG;
   wire dp_sys = dp.addr[31:12] == `FPC_PAGE_SYSCTL;
   wire w_fc = dp_reg && !dp_sys;
   wire w_sc = dp_reg && dp_sys;
   wire w_addr = w_fc && dp.addr[11:0] == `FPC_OFF_ADDR;
   wire w_data = w_fc && dp.addr[11:0] == `FPC_OFF_DATA;
   wire w_ctrl = w_fc && dp.addr[11:0] == `FPC_OFF_CTRL;
   wire w_im = w_fc && dp.addr[11:0] == `FPC_OFF_IM;
   wire w_misc = w_fc && dp.addr[11:0] == `FPC_OFF_MISC;
   wire w_pre0 = w_sc && dp.addr[11:0] == `FPC_OFF_PRE0;
   wire w_ppe0 = w_sc && dp.addr[11:0] == `FPC_OFF_PPE0;
   wire w_pre1 = w_sc && dp.addr[11:0] == `FPC_OFF_PRE1;
   wire w_ppe1 = w_sc && dp.addr[11:0] == `FPC_OFF_PPE1;
   wire w_usec = w_sc && dp.addr[11:0] == `FPC_OFF_USEC;

   // Plain read/write registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flash_address_reg <= 32'h0;
         fmd <= 32'h0;
         im <= 2'h0;
         usec <= `FPC_USEC_RESET;
      end
      else
      begin
         if (w_addr)
            flash_address_reg <= hwdata;
         if (w_data)
            fmd <= hwdata;
         if (w_im)
            im <= hwdata[1:0];
         if (w_usec)
            usec <= hwdata[7:0];
      end
   end

   // Power-on restore request, caught only by the power-on reset
   always_ff @(posedge hclk or negedge por_n)
   begin
      if (!por_n)
         restore <= 1'b1;
      else
         restore <= 1'b0;
   end

   // clear-only protection bits, restored from committed copy
   always_ff @(posedge hclk)
   begin
      if (restore)
      begin
         pre <= nv_pre;
         ppe <= nv_ppe;
      end
      else
      begin
         if (w_pre0)
            pre[31:0] <= pre[31:0] & hwdata;
         if (w_pre1)
            pre[63:32] <= pre[63:32] & hwdata;
         if (w_ppe0)
            ppe[31:0] <= ppe[31:0] & hwdata;
         if (w_ppe1)
            ppe[63:32] <= ppe[63:32] & hwdata;
      end
   end

   // Controller timing and operation decode
   wire ctl_start = w_ctrl && hwdata[31:16] == `FPC_KEY && state == fpc_pkg::FPC_IDLE && $onehot(hwdata[3:0]);
   wire [RGW-1:0] op_rgn = flash_address_reg[FAW+1:11];
   // program enable gates the targeted region
   wire op_allowed = ppe[op_rgn];
   wire walk_ok = ppe[walk[FAW-1:9]];
   // microsecond ticks from the cycle count register
   wire tick_end = state == fpc_pkg::FPC_WAIT && ucnt == 8'h0 && usec_left == 16'h1;
   wire walk_last = ctl_op[`FPC_CTL_MERASE] ? &walk : &walk[7:0];
   wire nv_commit = tick_end && ctl_op[`FPC_CTL_COMMIT] && flash_address_reg[31:2] == 30'h0;

   // Flash write port: programmed word or erased word
   wire fl_we = (tick_end && ctl_op[`FPC_CTL_WRITE] && op_allowed) || (state == fpc_pkg::FPC_WALK && walk_ok);
   wire [FAW-1:0] fl_widx = state == fpc_pkg::FPC_WALK ? walk : flash_address_reg[FAW+1:2];
   // programming ands data into the word
   wire [31:0] fl_wdata = state == fpc_pkg::FPC_WALK ? 32'hffff_ffff : flash_mem[flash_address_reg[FAW+1:2]] & fmd;

   // Flash controller sequence
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= fpc_pkg::FPC_IDLE;
         ctl_op <= 4'h0;
         ucnt <= 8'h0;
         usec_left <= 16'h0;
         walk <= '0;
         done_p <= 1'b0;
         viol_p <= 1'b0;
      end
      else
      begin
         done_p <= 1'b0;
         viol_p <= 1'b0;
         case (state)
            fpc_pkg::FPC_IDLE:
            begin
               if (ctl_start)
               begin
                  ctl_op <= hwdata[3:0];
                  ucnt <= usec;
                  usec_left <= (hwdata[`FPC_CTL_ERASE] || hwdata[`FPC_CTL_MERASE]) ? `FPC_ERASE_USEC : `FPC_PROG_USEC;
                  state <= fpc_pkg::FPC_WAIT;
               end
            end
            fpc_pkg::FPC_WAIT:
            begin
               if (ucnt == 8'h0)
               begin
                  ucnt <= usec;
                  usec_left <= usec_left - 16'h1;
               end
               else
                  ucnt <= ucnt - 8'h1;
               if (tick_end)
               begin
                  // refused operation ends without touching flash
                  if (ctl_op[`FPC_CTL_MERASE] || (ctl_op[`FPC_CTL_ERASE] && op_allowed))
                  begin
                     // erase walks one 1 KB unit or the whole array
                     walk <= ctl_op[`FPC_CTL_MERASE] ? '0 : {flash_address_reg[FAW+1:10], 8'h00};
                     state <= fpc_pkg::FPC_WALK;
                  end
                  else
                  begin
                     viol_p <= !ctl_op[`FPC_CTL_COMMIT] && !op_allowed;
                     done_p <= ctl_op[`FPC_CTL_COMMIT] || op_allowed;
                     ctl_op <= 4'h0;
                     state <= fpc_pkg::FPC_IDLE;
                  end
               end
            end
            fpc_pkg::FPC_WALK:
            begin
               viol_p <= !walk_ok;
               walk <= walk + 1'b1;
               if (walk_last)
               begin
                  done_p <= 1'b1;
                  ctl_op <= 4'h0;
                  state <= fpc_pkg::FPC_IDLE;
               end
            end
            default:
               state <= fpc_pkg::FPC_IDLE;
         endcase
      end
   end

   // Flash array, nonvolatile and without reset
   always_ff @(posedge hclk)
   begin
      if (fl_we)
         flash_mem[fl_widx] <= fl_wdata;
   end

   // committed protection copy, set back to all ones only by factory recovery
   always_ff @(posedge hclk or negedge factory_n)
   begin
      if (!factory_n)
      begin
         nv_pre <= {`FPC_PROT_RESET, `FPC_PROT_RESET};
         nv_ppe <= {`FPC_PROT_RESET, `FPC_PROT_RESET};
      end
      else if (nv_commit)
      begin
         case (flash_address_reg[1:0])
            2'h0: nv_pre[31:0] <= pre[31:0];
            2'h1: nv_ppe[31:0] <= ppe[31:0];
            2'h2: nv_pre[63:32] <= pre[63:32];
            default: nv_ppe[63:32] <= ppe[63:32];
         endcase
      end
   end

   // write-one clear, a same-cycle event wins
   wire [1:0] ris_set = {done_p, viol_p};
   wire [1:0] ris_clr = w_misc ? hwdata[1:0] : 2'h0;
   // Raw status and the masked interrupt line
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ris <= 2'h0;
         flash_irq <= 1'b0;
      end
      else
      begin
         // raw flags set regardless of mask
         ris <= (ris & ~ris_clr) | ris_set;
         flash_irq <= |(ris & im);
      end
   end

   // Checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   a_fault_on_data: assert property (rd_ok && rd_fault |=> bus_fault && hrdata == 32'h0)
      else $error("protected data read not faulted");
   a_fetch_allowed: assert property (rd_ok && req.fetch |=> !bus_fault)
      else $error("instruction fetch faulted");
   a_same_bank_stall: assert property (req_valid && same_bank && !flash_held |=> s_one_wait)
      else $error("same bank read did not stall exactly one cycle");
   a_other_bank_go: assert property (req_valid && !conflict && dp_wr && dp_ram && req_ram |=> hreadyout)
      else $error("other bank read stalled");
   a_prot_clear_only: assert property (!restore ##1 !restore |-> (pre & ~$past(pre)) == 64'h0)
      else $error("protection bit rose without restore");
   a_refused_write: assert property (tick_end && ctl_op[`FPC_CTL_WRITE] && !op_allowed
      |-> !fl_we ##1 viol_p && ctl_op == 4'h0 ##1 ris[`FPC_IRQ_ACCESS])
      else $error("refused program not flagged");
   a_prog_done: assert property (tick_end && ctl_op[`FPC_CTL_WRITE] && op_allowed
      |=> state == fpc_pkg::FPC_IDLE ##1 ris[`FPC_IRQ_PROG])
      else $error("program completion not flagged");
   a_irq_masked: assert property ((ris & im) == 2'h0 [*2] |-> !flash_irq)
      else $error("interrupt without masked status");
   a_irq_raised: assert property ((ris & im) != 2'h0 [*2] |-> flash_irq)
      else $error("masked status without interrupt");
   a_clear_w1c: assert property (w_misc && hwdata[`FPC_IRQ_PROG] && !done_p |=> !ris[`FPC_IRQ_PROG])
      else $error("write one did not clear status");
   a_timer_start: assert property (ctl_start |=> state == fpc_pkg::FPC_WAIT && ucnt == $past(usec))
      else $error("operation timer not loaded from cycle count");
   a_erase_ones: assert property (state == fpc_pkg::FPC_WALK && walk_ok
      |=> flash_mem[$past(walk)] == 32'hffff_ffff)
      else $error("erase left a zero bit");
endmodule : fpc_flash_protect
`default_nettype wire

// ---- fpc_master_model.sv ----
// Bus master model issuing single and back-to-back AHB-Lite word transfers
`timescale 1ns/1ps
`default_nettype none
module fpc_master_model (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic bus_fault,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [3:0] hprot,
   output logic [31:0] hwdata,
   output logic hung
);
   // Quiet bus at time zero
   initial
   begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hprot = 4'h3;
      hwdata = 32'h0;
      hung = 1'b0;
   end

   // Waits for hready at a rising edge; n counts the stalled edges
   task automatic wt(output int n);
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 5000)
      begin
         n++;
         @(posedge hclk);
      end
      if (n >= 5000)
         hung <= 1'b1;
   endtask : wt

   // Address phase; hprot bit 0 low marks an instruction fetch
   task automatic ap(input logic [31:0] a, input logic w, input logic f);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hprot <= f ? 4'h2 : 4'h3;
   endtask : ap

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int n;
      ap(a, 1'b1, 1'b0);
      wt(n);
      htrans <= 2'b00;
      hwdata <= d;
      wt(n);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic f, output logic [31:0] d, output logic bf);
      int n;
      ap(a, 1'b0, f);
      wt(n);
      htrans <= 2'b00;
      wt(n);
      d = hrdata;
      bf = bus_fault;
   endtask : rd

   // Write whose data phase overlaps the address phase of a read
   task automatic wr_rd(input logic [31:0] wa, input logic [31:0] wd, input logic [31:0] ra,
                        output logic [31:0] d, output int n);
      ap(wa, 1'b1, 1'b0);
      wt(n);
      ap(ra, 1'b0, 1'b0);
      hwdata <= wd;
      wt(n);
      htrans <= 2'b00;
      wt(n);
      d = hrdata;
   endtask : wr_rd
endmodule : fpc_master_model
`default_nettype wire

// ---- flash_protect_and_sram_bank_ctrl_test.sv ----
// Self-checking bench of the flash protect and SRAM bank block
`include "fpc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_protect_and_sram_bank_ctrl_test;
   typedef struct packed {logic [31:0] a; logic [31:0] e;} fpc_row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic por_n = 1'b0;
   logic factory_n = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, bus_fault, flash_irq, hung, bf;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] hprot;
   fpc_row_t rows [8];
   int error_cnt = 0;
   int n_tests = 0;
   int t0, t1, n;

   always #25 hclk = ~hclk;

   fpc_master_model m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .bus_fault(bus_fault),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
      .hwdata(hwdata), .hung(hung));

   fpc_flash_protect #(.FLASH_KB(128), .SRAM_KB(32)) dut (.hclk(hclk), .hresetn(hresetn),
      .por_n(por_n), .factory_n(factory_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_fault(bus_fault),
      .flash_irq(flash_irq));

   function automatic logic [31:0] fa(input logic [11:0] o);
      return {`FPC_PAGE_FLASHCTL, o};
   endfunction : fa

   function automatic logic [31:0] sa(input logic [11:0] o);
      return {`FPC_PAGE_SYSCTL, o};
   endfunction : sa

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic f;
      m.rd(a, 1'b0, v, f);
      chk(v, e);
   endtask : rdc

   // Starts a keyed operation and polls the control word; t is its length in cycles
   task automatic op(input logic [3:0] c, output int t);
      logic [31:0] v;
      logic f;
      int i;
      time ts;
      m.wr(fa(`FPC_OFF_CTRL), {`FPC_KEY, 12'h000, c});
      ts = $time;
      i = 0;
      do
      begin
         m.rd(fa(`FPC_OFF_CTRL), 1'b0, v, f);
         i++;
      end
      while (v !== 32'h0 && i < 40000);
      t = int'(($time - ts) / 50);
      if (i >= 40000)
      begin
         error_cnt++;
         print_verdict();
      end
   endtask : op

   task automatic rst(input logic p);
      hresetn <= 1'b0;
      por_n <= ~p;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge hclk);
   endtask : rst

   // A hung handshake ends the run
   always @(posedge hung)
   begin
      error_cnt++;
      print_verdict();
   end

   initial
   begin
      rows = '{'{sa(`FPC_OFF_USEC), {24'h0, `FPC_USEC_RESET}}, '{sa(`FPC_OFF_PRE0), `FPC_PROT_RESET},
         '{sa(`FPC_OFF_PPE0), `FPC_PROT_RESET}, '{sa(`FPC_OFF_PRE1), `FPC_PROT_RESET},
         '{sa(`FPC_OFF_PPE1), `FPC_PROT_RESET}, '{fa(`FPC_OFF_RIS), 32'h0},
         '{fa(`FPC_OFF_IM), 32'h0}, '{32'h4000_0000, 32'h0}};
      repeat (5) @(posedge hclk);
      factory_n <= 1'b1;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge hclk);
      // Reset values and an unmapped place
      foreach (rows[i])
         rdc(rows[i].a, rows[i].e);
      // Zero reload value, then a mass erase and a write-one clear of its status
      m.wr(sa(`FPC_OFF_USEC), 32'h0);
      op(4'h4, t0);
      rdc(32'h0, 32'hffff_ffff);
      rdc(fa(`FPC_OFF_RIS), 32'h2);
      m.wr(fa(`FPC_OFF_MISC), 32'h0);
      rdc(fa(`FPC_OFF_RIS), 32'h2);
      m.wr(fa(`FPC_OFF_MISC), 32'h2);
      rdc(fa(`FPC_OFF_RIS), 32'h0);
      // Program twice; second one with a longer reload value
      m.wr(fa(`FPC_OFF_ADDR), 32'h0);
      m.wr(fa(`FPC_OFF_DATA), 32'h1234_5678);
      op(4'h1, t0);
      m.wr(sa(`FPC_OFF_USEC), 32'h1);
      m.wr(fa(`FPC_OFF_DATA), 32'hffff_0000);
      op(4'h1, t1);
      rdc(32'h0, 32'h1234_0000);
      chk({31'h0, ((t1 - t0) inside {[18:22]})}, 32'h1);
      // Program and erase refused on region 0
      m.wr(fa(`FPC_OFF_MISC), 32'h3);
      m.wr(sa(`FPC_OFF_PPE0), 32'hffff_fffe);
      m.wr(fa(`FPC_OFF_DATA), 32'h0);
      for (int c = 0; c < 2; c++)
      begin
         op(c == 0 ? 4'h1 : 4'h2, t0);
         rdc(32'h0, 32'h1234_0000);
         rdc(fa(`FPC_OFF_RIS), 32'h1);
         rdc(fa(`FPC_OFF_MISC), 32'h0);
         chk({31'h0, flash_irq}, 32'h0);
         m.wr(fa(`FPC_OFF_IM), 32'h1);
         rdc(fa(`FPC_OFF_MISC), 32'h1);
         chk({31'h0, flash_irq}, 32'h1);
         m.wr(fa(`FPC_OFF_MISC), 32'h1);
         m.wr(fa(`FPC_OFF_IM), 32'h0);
         rdc(fa(`FPC_OFF_RIS), 32'h0);
      end
      m.wr(sa(`FPC_OFF_PPE0), 32'hffff_ffff);
      rdc(sa(`FPC_OFF_PPE0), 32'hffff_fffe);
      // Region 0 made execute-only; region 1 stays open
      m.wr(sa(`FPC_OFF_PRE0), 32'hffff_fffe);
      m.rd(32'h0, 1'b0, d, bf);
      chk(d, 32'h0);
      chk({31'h0, bf}, 32'h1);
      chk({31'h0, hresp}, 32'h0);
      m.rd(32'h0, 1'b1, d, bf);
      chk(d, 32'h1234_0000);
      m.rd(32'h800, 1'b0, d, bf);
      chk({bf, d[30:0]}, 32'h7fff_ffff);
      rst(1'b0);
      rdc(sa(`FPC_OFF_PRE0), 32'hffff_fffe);
      // Commit program enables 0-31, then power-on reset
      m.wr(fa(`FPC_OFF_ADDR), 32'h1);
      op(4'h8, t0);
      rst(1'b1);
      rdc(sa(`FPC_OFF_PRE0), 32'hffff_ffff);
      rdc(sa(`FPC_OFF_PPE0), 32'hffff_fffe);
      // Back-to-back SRAM write and read
      m.wr_rd(32'h2000_0000, 32'ha5, 32'h2000_0000, d, n);
      chk(d, 32'ha5);
      chk(32'(n), 32'h1);
      m.wr_rd(32'h2000_0004, 32'h5a, 32'h2000_0000, d, n);
      chk(d, 32'ha5);
      chk(32'(n), 32'h0);
      // Bit 3 of the byte at 0x2000_1000 through its alias
      m.wr(32'h2000_1000, 32'h0);
      m.wr(32'h2202_000c, 32'h1);
      rdc(32'h2000_1000, 32'h8);
      rdc(32'h2202_000c, 32'h1);
      rdc(32'h2202_0008, 32'h0);
      print_verdict();
   end
endmodule : flash_protect_and_sram_bank_ctrl_test
`default_nettype wire
